/* mbsrs_pkg.sv */
// Shared constants, state codes and carrier types for the sensor register responder.
package mbsrs_pkg;

  // ****************************************************************
  // Function codes, exception codes and frame constants.
  // ****************************************************************
  localparam logic [7:0] FC_COIL_READ = 8'h01;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_COIL_FORCE = 8'h05;
  localparam logic [7:0] FC_PRESET_ONE = 8'h06;
  localparam logic [7:0] FC_COIL_FORCE_MULTI = 8'h0F;
  localparam logic [7:0] FC_PRESET_MULTI = 8'h10;
  localparam logic [7:0] FC_EXCEPTION_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [7:0] MIN_FRAME_LEN = 8'h04;
  localparam logic [7:0] READ_FRAME_LEN = 8'h08;
  localparam logic [4:0] EXC_HDR_LEN = 5'h03;

  // ****************************************************************
  // Sensor register map: register number 2000 + 100 * x + word.
  // ****************************************************************
  localparam int SENSOR_COUNT = 8;
  localparam logic [15:0] MAP_BASE = 16'h07D0;
  localparam logic [15:0] SENSOR_STRIDE = 16'h0064;
  localparam logic [3:0] SENSOR_WORDS = 4'h9;
  localparam logic [3:0] W_CONCENTRATION = 4'h0;
  localparam logic [3:0] W_STATUS = 4'h1;
  localparam logic [3:0] W_FIRMWARE = 4'h2;
  localparam logic [3:0] W_LOW_SETPOINT = 4'h3;
  localparam logic [3:0] W_MID_SETPOINT = 4'h4;
  localparam logic [3:0] W_HIGH_SETPOINT = 4'h5;
  localparam logic [3:0] W_CALIBRATION = 4'h6;
  localparam logic [3:0] W_RANGE = 4'h7;
  localparam logic [3:0] W_GAS_FACTOR = 4'h8;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [0:0] {
    ST_RECEIVE = 1'b0,
    ST_SEND = 1'b1
  } mbsrs_state_t;

  // Operating status word, laid out from bit 15 down to bit 0.
  typedef struct packed {
    logic [7:0] status_code;
    logic calibrating;
    logic missing;
    logic warming;
    logic cell_warning;
    logic self_testing;
    logic fault;
    logic [1:0] alarm_level;
  } mbsrs_status_t;

  // Everything one sensor reports; scaled values are multiplied by gas_factor.
  typedef struct packed {
    logic [15:0] concentration;
    mbsrs_status_t status;
    logic [7:0] firmware;
    logic [15:0] low_setpoint;
    logic [15:0] mid_setpoint;
    logic [15:0] high_setpoint;
    logic [15:0] calibration;
    logic [15:0] range;
    logic [15:0] gas_factor;
  } mbsrs_sensor_t;

endpackage

/* mbsrs_responder.sv */
// Request handler that answers Modbus RTU frames from the per-sensor register map.
`timescale 1ns/1ps

// How it works
// - Function code byte; six codes are defined.
// - Registers for 3, 6, 16; coils raise exception.
// - Silent on foreign address, bad CRC, broadcast.
// - Unmapped register address answers exception code 2.
// - Unimplemented function code answers exception code 1.
// - Exception echoes function code with top bit set.
// - Exception: address, code, exception, CRC low, high.
// - Normal answer echoes function code unchanged.
// - CRC from FFFF, shift right, XOR A001.
// - Read returns consecutive 16-bit words from start.
// - Broadcast read is neither executed nor answered.
// - Eight sensors, concentration at register scaled_gas_concentration.
// - Status bits 1:0 give alarm level.
// - Status bits 2..4: fault, self test, cell warning.
// - Status bits 5..7: warm-up, missing, calibrating.
// - Status bits 15:8 carry sensor status code.
// - Word sensor_firmware_version reports firmware version 1..255.
// - Words scaled_low_alarm_setpoint..scaled_high_alarm_setpoint hold alarm set points.
// - Words scaled_calibration_value, scaled_range_value hold calibration and range.
// - Word gas_scale_factor holds gas factor for scaling.
module mbsrs_responder (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Own slave address and live sensor data, from logic on this clock.
  input wire logic [7:0] slave_addr,
  input wire mbsrs_pkg::mbsrs_sensor_t sensor_in [mbsrs_pkg::SENSOR_COUNT],
  // Received bytes and end-of-frame mark from the framing layer.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_eof,
  // Response bytes towards the framing layer.
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // One byte step of the frame check; shared by receive and send.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mbsrs_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Picks one register word of a sensor; an index past the map reads zero.
  function automatic logic [15:0] sensor_word(input mbsrs_pkg::mbsrs_sensor_t s,
                                              input logic [3:0] w);
    logic [15:0] v;
    v = 16'h0000;
    unique case (w)
      mbsrs_pkg::W_CONCENTRATION: v = s.concentration;
      mbsrs_pkg::W_STATUS: v = s.status;
      mbsrs_pkg::W_FIRMWARE: v = {8'h00, s.firmware};
      mbsrs_pkg::W_LOW_SETPOINT: v = s.low_setpoint;
      mbsrs_pkg::W_MID_SETPOINT: v = s.mid_setpoint;
      mbsrs_pkg::W_HIGH_SETPOINT: v = s.high_setpoint;
      mbsrs_pkg::W_CALIBRATION: v = s.calibration;
      mbsrs_pkg::W_RANGE: v = s.range;
      mbsrs_pkg::W_GAS_FACTOR: v = s.gas_factor;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Receive side: byte capture, length and running check value.
  // ****************************************************************
  mbsrs_pkg::mbsrs_state_t state; // Receive or send phase.
  logic [7:0] rx_buf [6]; // Address, function code and four data bytes.
  logic [7:0] rx_len; // Bytes seen in this frame, saturating.
  logic [15:0] rx_crc; // Running check; zero after a good frame.
  logic [4:0] tx_idx; // Index of the byte now offered.
  logic [15:0] tx_crc; // Check value over bytes already sent.
  logic resp_exc; // Current answer is an exception.
  logic [7:0] resp_fc; // Function code of the request.
  logic [7:0] resp_exc_code; // Exception code to send.
  logic [2:0] rd_sensor; // Sensor index 0..7 of a read.
  logic [3:0] rd_word; // First word of the read within the sensor.
  logic [4:0] rd_count; // Number of words to return.
  logic [4:0] hdr_len; // Bytes before the check value.

  // Capture bytes while receiving; a frame end resets the byte count and check value, the buffer keeps its bytes.
  // Bytes arriving while answering are dropped: the line is half duplex.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_len <= 8'h00;
      rx_crc <= mbsrs_pkg::CRC_INIT;
      for (int i = 0; i < 6; i++) begin
        rx_buf[i] <= 8'h00;
      end
    end else if (state != mbsrs_pkg::ST_RECEIVE || rx_eof) begin
      rx_len <= 8'h00;
      rx_crc <= mbsrs_pkg::CRC_INIT;
    end else if (rx_valid) begin
      if (rx_len < 8'h06) begin
        rx_buf[rx_len[2:0]] <= rx_data;
      end
      if (rx_len != 8'hFF) begin
        rx_len <= rx_len + 8'h01;
      end
      rx_crc <= crc_byte(rx_crc, rx_data);
    end
  end

  // ****************************************************************
  // Request decode, evaluated on the frame end.
  // ****************************************************************
  logic [15:0] req_start; // Requested first register.
  logic [15:0] req_count; // Requested number of registers.
  logic map_hit; // Start register lies in the sensor map.
  logic [2:0] map_sensor; // Sensor index of the start register.
  logic [3:0] map_word; // Word index of the start register.
  logic frame_ok; // Frame is ours, long enough and intact.
  logic dec_exc; // Decision: answer with an exception.
  logic [7:0] dec_code; // Decision: exception code.

  assign req_start = {rx_buf[2], rx_buf[3]};
  assign req_count = {rx_buf[4], rx_buf[5]};

  // Finds the sensor and word of the start register by range compare,
  // which avoids a divider for the decimal stride of the map.
  always_comb begin
    logic [15:0] base;
    logic [15:0] off;
    base = mbsrs_pkg::MAP_BASE;
    off = 16'h0000;
    map_hit = 1'b0;
    map_sensor = 3'h0;
    map_word = 4'h0;
    for (int s = 0; s < mbsrs_pkg::SENSOR_COUNT; s++) begin
      base = base + mbsrs_pkg::SENSOR_STRIDE;
      off = req_start - base;
      if (req_start >= base && off < {12'h000, mbsrs_pkg::SENSOR_WORDS}) begin
        map_hit = 1'b1;
        map_sensor = 3'(s);
        map_word = off[3:0];
      end
    end
  end

  // A frame is answered only if addressed to us, not broadcast, and intact.
  assign frame_ok = (rx_len >= mbsrs_pkg::MIN_FRAME_LEN) && (rx_crc == 16'h0000)
                    && (rx_buf[0] == slave_addr)
                    && (rx_buf[0] != mbsrs_pkg::BROADCAST_ADDR);

  // Chooses a normal answer or the exception code for the request.
  always_comb begin
    dec_exc = 1'b1;
    dec_code = mbsrs_pkg::EXC_ILLEGAL_FUNCTION;
    unique case (rx_buf[1])
      mbsrs_pkg::FC_READ_HOLD: begin
        dec_code = mbsrs_pkg::EXC_ILLEGAL_ADDRESS;
        if (rx_len >= mbsrs_pkg::READ_FRAME_LEN && map_hit && req_count != 16'h0000
            && req_count <= {12'h000, mbsrs_pkg::SENSOR_WORDS - map_word}) begin
          dec_exc = 1'b0;
        end
      end
      mbsrs_pkg::FC_PRESET_ONE, mbsrs_pkg::FC_PRESET_MULTI: begin
        dec_code = mbsrs_pkg::EXC_ILLEGAL_ADDRESS;
      end
      mbsrs_pkg::FC_COIL_READ, mbsrs_pkg::FC_COIL_FORCE,
      mbsrs_pkg::FC_COIL_FORCE_MULTI: begin
        dec_code = mbsrs_pkg::EXC_ILLEGAL_FUNCTION;
      end
      default: begin
        dec_code = mbsrs_pkg::EXC_ILLEGAL_FUNCTION;
      end
    endcase
  end

  // ****************************************************************
  // Phase control and latched answer.
  // ****************************************************************
  logic accept; // Offered byte taken by the framing layer.
  logic [15:0] next_crc; // Check value including the byte being taken.
  logic [7:0] next_byte; // Byte to offer after the one being taken.
  logic [4:0] next_idx; // Index of that byte.

  assign accept = tx_valid && tx_ready;
  assign tx_valid = (state == mbsrs_pkg::ST_SEND);
  assign tx_last = tx_valid && (tx_idx == hdr_len + 5'h01);
  assign next_idx = tx_idx + 5'h01;
  assign next_crc = crc_byte(tx_crc, tx_data);

  // Enters the send phase on a valid frame end and leaves after the last byte.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= mbsrs_pkg::ST_RECEIVE;
    end else if (state == mbsrs_pkg::ST_RECEIVE && rx_eof && frame_ok) begin
      state <= mbsrs_pkg::ST_SEND;
    end else if (accept && tx_last) begin
      state <= mbsrs_pkg::ST_RECEIVE;
    end
  end

  // Latches the decision so the answer does not depend on later rx bytes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resp_exc <= 1'b0;
      resp_fc <= 8'h00;
      resp_exc_code <= 8'h00;
      rd_sensor <= 3'h0;
      rd_word <= 4'h0;
      rd_count <= 5'h00;
      hdr_len <= mbsrs_pkg::EXC_HDR_LEN;
    end else if (state == mbsrs_pkg::ST_RECEIVE && rx_eof && frame_ok) begin
      resp_exc <= dec_exc;
      resp_fc <= rx_buf[1];
      resp_exc_code <= dec_code;
      rd_sensor <= map_sensor;
      rd_word <= map_word;
      rd_count <= dec_exc ? 5'h00 : req_count[4:0];
      hdr_len <= dec_exc ? mbsrs_pkg::EXC_HDR_LEN
                         : mbsrs_pkg::EXC_HDR_LEN + {req_count[3:0], 1'b0};
    end
  end

  // ****************************************************************
  // Transmit byte sequencing.
  // ****************************************************************

  // Builds the byte that follows the one being taken.
  always_comb begin
    logic [4:0] doff;
    logic [15:0] w;
    doff = next_idx - mbsrs_pkg::EXC_HDR_LEN;
    w = sensor_word(sensor_in[rd_sensor], rd_word + doff[4:1]);
    if (next_idx == 5'h01) begin
      next_byte = resp_exc ? (resp_fc | mbsrs_pkg::FC_EXCEPTION_FLAG) : resp_fc;
    end else if (next_idx == hdr_len) begin
      next_byte = next_crc[7:0];
    end else if (next_idx == hdr_len + 5'h01) begin
      // The low check byte being taken must not be folded in, so use the settled value.
      next_byte = tx_crc[15:8];
    end else if (next_idx == 5'h02) begin
      next_byte = resp_exc ? resp_exc_code : {2'b00, rd_count, 1'b0};
    end else begin
      next_byte = doff[0] ? w[7:0] : w[15:8];
    end
  end

  // Offers the own address first, then walks the answer byte by byte.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_data <= 8'h00;
      tx_idx <= 5'h00;
      tx_crc <= mbsrs_pkg::CRC_INIT;
    end else if (state == mbsrs_pkg::ST_RECEIVE) begin
      tx_data <= slave_addr;
      tx_idx <= 5'h00;
      tx_crc <= mbsrs_pkg::CRC_INIT;
    end else if (accept) begin
      tx_data <= next_byte;
      tx_idx <= next_idx;
      tx_crc <= next_crc;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_exc_fc_msb: assert property (@(posedge clk) disable iff (!nrst)
    (tx_valid && tx_idx == 5'h01 && resp_exc) |-> tx_data == (resp_fc | 8'h80))
    else $error("Exception function code lacks top bit.");

  a_normal_fc_echo: assert property (@(posedge clk) disable iff (!nrst)
    (tx_valid && tx_idx == 5'h01 && !resp_exc) |-> tx_data == resp_fc)
    else $error("Normal answer changed the function code.");

  a_first_byte_addr: assert property (@(posedge clk) disable iff (!nrst)
    $rose(tx_valid) |-> (tx_idx == 5'h00 && tx_data == $past(slave_addr)))
    else $error("Answer does not open with own address.");

  a_exc_length: assert property (@(posedge clk) disable iff (!nrst)
    (tx_valid && resp_exc) |-> (hdr_len == 5'h03 && (tx_idx == 5'h04) == tx_last))
    else $error("Exception answer has wrong length.");

  a_silent_bad: assert property (@(posedge clk) disable iff (!nrst)
    (!tx_valid && rx_eof && (rx_crc != 16'h0000 || rx_buf[0] != slave_addr))
    |=> !tx_valid [*2])
    else $error("Answered a foreign or damaged frame.");

  a_silent_bcast: assert property (@(posedge clk) disable iff (!nrst)
    (!tx_valid && rx_eof && rx_buf[0] == 8'h00) |=> !tx_valid)
    else $error("Answered a broadcast frame.");

  a_preset_refused: assert property (@(posedge clk) disable iff (!nrst)
    (!tx_valid && rx_eof && frame_ok && (rx_buf[1] == 8'h06 || rx_buf[1] == 8'h10))
    |=> (resp_exc && resp_exc_code == 8'h02))
    else $error("Preset request was not refused with code 2.");

  a_unknown_fc: assert property (@(posedge clk) disable iff (!nrst)
    (!tx_valid && rx_eof && frame_ok && rx_buf[1] == 8'h07)
    |=> (resp_exc && resp_exc_code == 8'h01))
    else $error("Unknown function code not refused with code 1.");

  a_coil_refused: assert property (@(posedge clk) disable iff (!nrst)
    (!tx_valid && rx_eof && frame_ok && (rx_buf[1] == 8'h01 || rx_buf[1] == 8'h05))
    |=> resp_exc)
    else $error("Coil request executed.");

  a_crc_residue: assert property (@(posedge clk) disable iff (!nrst)
    (accept && tx_last) |-> crc_byte(tx_crc, tx_data) == 16'h0000)
    else $error("Sent check value does not close the frame.");

  a_read_len: assert property (@(posedge clk) disable iff (!nrst)
    (tx_valid && !resp_exc) |-> (rd_count != 5'h00 && hdr_len == 5'h03 + {rd_count[3:0], 1'b0}))
    else $error("Read answer length does not match count.");

endmodule

/* mbsrs_master_model.sv */
// Behavioural bus master that sends request frames and takes response bytes.
`timescale 1ns/1ps
module mbsrs_master_model (
  // Clock.
  input wire logic clk,
  // Stall mode: when high, a response byte is taken only one cycle in three.
  input wire logic slow,
  // Request bytes towards the responder.
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_eof,
  // Response acceptance.
  output logic tx_ready
);
  // Pacing count for slow mode.
  logic [1:0] pace = 2'h0;

  // Idle levels at time zero; idle data is never left at a real byte.
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_eof = 1'b0;
    tx_ready = 1'b0;
  end

  // Ready moves just after each edge, so the responder sees it settled.
  always @(posedge clk) begin
    #1;
    pace = (pace == 2'h2) ? 2'h0 : pace + 2'h1;
    tx_ready = !slow || (pace == 2'h0);
  end

  // Reflected check value: start at all ones, shift right, fold in A001 on a one.
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Sends the bytes, the check value low byte first, then the end mark.
  // A bad check value flips one bit so the frame must be dropped.
  task automatic send(input logic [7:0] q[$], input bit bad_crc);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0] ^ {7'h00, bad_crc});
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(posedge clk);
      #1;
      rx_valid = 1'b1;
      rx_data = q[i];
    end
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_eof = 1'b1;
    @(posedge clk);
    #1;
    rx_eof = 1'b0;
  endtask
endmodule

/* mbsrs_responder_tb_top.sv */
// Self-checking bench for the sensor register responder.
`timescale 1ns/1ps
module mbsrs_responder_tb_top;
  // ****************************************************************
  // Signals and bookkeeping.
  // ****************************************************************
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic slow = 1'b0;
  logic [7:0] slave_addr = 8'h11;
  mbsrs_pkg::mbsrs_sensor_t sensor_in [mbsrs_pkg::SENSOR_COUNT];
  logic rx_valid, rx_eof, tx_valid, tx_ready, tx_last;
  logic [7:0] rx_data, tx_data;
  logic [8:0] exp_q[$]; // Expected bytes; bit 8 marks the last byte.
  logic [7:0] fc_tab [6] = '{8'h01, 8'h05, 8'h0F, 8'h06, 8'h10, 8'h07};
  logic [159:0] raw;
  int error_cnt = 0;
  int num_checks = 0;
  integer seed = 32'he754;

  always #2.5 clk = ~clk;

  mbsrs_responder mbsrs_responder_inst (.clk(clk), .nrst(nrst), .slave_addr(slave_addr),
    .sensor_in(sensor_in), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
  mbsrs_master_model mbsrs_master_model_inst (.clk(clk), .slow(slow), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_eof(rx_eof), .tx_ready(tx_ready));

  // ****************************************************************
  // Checking.
  // ****************************************************************
  task automatic final_report();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp_byte(input string what, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Every accepted byte is compared with the oldest note; a byte with no note is an error.
  always @(posedge clk) begin
    if (nrst === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_checks++;
        error_cnt++;
        $display("[FAIL] response byte expected none seen %h", tx_data);
      end else begin
        cmp_byte("response byte", exp_q.pop_front(), {tx_last, tx_data});
      end
    end
  end

  // Hang guard for the whole run.
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  // ****************************************************************
  // Stimulus helpers.
  // ****************************************************************
  // Status word is rebuilt field by field so a bit-order slip shows up.
  function automatic logic [15:0] word_of(input mbsrs_pkg::mbsrs_sensor_t s, input int w);
    case (w)
      0: return s.concentration;
      1: return {s.status.status_code, s.status.calibrating, s.status.missing,
        s.status.warming, s.status.cell_warning, s.status.self_testing,
        s.status.fault, s.status.alarm_level};
      2: return {8'h00, s.firmware};
      3: return s.low_setpoint;
      4: return s.mid_setpoint;
      5: return s.high_setpoint;
      6: return s.calibration;
      7: return s.range;
      default: return s.gas_factor;
    endcase
  endfunction

  // Notes one response plus its check value, low byte first.
  task automatic expect_resp(input logic [7:0] q[$]);
    logic [15:0] c;
    c = mbsrs_master_model_inst.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      exp_q.push_back({i == q.size() - 1, q[i]});
    end
  endtask

  // Sends a request and waits, bounded, until all notes are used and the line is idle.
  task automatic xfer(input logic [7:0] q[$], input bit bad_crc);
    int n;
    mbsrs_master_model_inst.send(q, bad_crc);
    n = 0;
    while ((exp_q.size() != 0 || tx_valid !== 1'b0) && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    #1;
    if (n >= 400) begin
      error_cnt++;
      $display("[FAIL] response wait expected done seen timeout");
      final_report();
    end
  endtask

  // Reads cnt words from word w of sensor x; out-of-map reads expect exception 2.
  task automatic rd(input int x, input int w, input int cnt);
    logic [7:0] r[$];
    logic [15:0] reg_no, wv;
    reg_no = 16'(2000 + 100 * x + w);
    if (x >= 1 && x <= 8 && w <= 8 && cnt >= 1 && w + cnt <= 9) begin
      r = {slave_addr, 8'h03, 8'(2 * cnt)};
      for (int k = 0; k < cnt; k++) begin
        wv = word_of(sensor_in[x - 1], w + k);
        r.push_back(wv[15:8]);
        r.push_back(wv[7:0]);
      end
      expect_resp(r);
    end else begin
      expect_resp({slave_addr, 8'h83, 8'h02});
    end
    xfer({slave_addr, 8'h03, reg_no[15:8], reg_no[7:0], 8'h00, 8'(cnt)}, 1'b0);
  endtask

  task automatic rand_sensors();
    foreach (sensor_in[i]) begin
      raw = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      sensor_in[i] = raw[135:0];
      if (sensor_in[i].firmware == 8'h00) begin
        sensor_in[i].firmware = 8'h01;
      end
    end
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    foreach (sensor_in[i]) begin
      sensor_in[i] = '0;
    end
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    // Worked examples: unmapped read, and a bare four-byte undefined function.
    slave_addr = 8'h01;
    expect_resp({8'h01, 8'h83, 8'h02});
    xfer({8'h01, 8'h03, 8'h01, 8'h5B, 8'h00, 8'h03}, 1'b0);
    slave_addr = 8'h11;
    expect_resp({8'h11, 8'h87, 8'h01});
    xfer({8'h11, 8'h07}, 1'b0);
    // Coil codes get exception 1; presets to read-only words get exception 2.
    foreach (fc_tab[i]) begin
      expect_resp({8'h11, fc_tab[i] | 8'h80,
        (fc_tab[i] inside {8'h06, 8'h10}) ? 8'h02 : 8'h01});
      xfer({8'h11, fc_tab[i], 8'h08, 8'h34, 8'h00, 8'h01}, 1'b0);
    end
    // Dropped frames: foreign address, bad check value, broadcast, too short.
    xfer({8'h12, 8'h03, 8'h08, 8'h34, 8'h00, 8'h01}, 1'b0);
    xfer({8'h11, 8'h03, 8'h08, 8'h34, 8'h00, 8'h01}, 1'b1);
    xfer({8'h00, 8'h03, 8'h08, 8'h34, 8'h00, 8'h01}, 1'b0);
    xfer({8'h11}, 1'b0);
    // A read frame cut short before its count field is refused with code 2.
    expect_resp({8'h11, 8'h83, 8'h02});
    xfer({8'h11, 8'h03, 8'h08, 8'h34}, 1'b0);
    // A reset between frames must leave the responder ready for the next one.
    nrst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    rand_sensors();
    // Edges of the map: full sensor, last word, crossing, zero count, gaps.
    rd(1, 0, 9);
    rd(8, 8, 1);
    rd(8, 8, 2);
    rd(1, 0, 0);
    rd(1, 9, 1);
    rd(9, 0, 1);
    rd(0, 0, 1);
    // Random reads with fresh data and random stalls from the master.
    for (int t = 0; t < 30; t++) begin
      rand_sensors();
      slow = 1'($random(seed));
      rd(1 + $unsigned($random(seed)) % 9, $unsigned($random(seed)) % 10,
        $unsigned($random(seed)) % 10);
    end
    final_report();
  end
endmodule
